// file: odtc_defs.svh
`ifndef ODTC_DEFS_SVH
`define ODTC_DEFS_SVH

// ****************************************
// Instruction field positions
// ****************************************
`define ODTC_F_OP 31:30
`define ODTC_F_RD 29:25
`define ODTC_F_OP2 24:22
`define ODTC_F_OP3 24:19
`define ODTC_F_RS1 18:14
`define ODTC_F_I 13
`define ODTC_F_X 12
`define ODTC_F_OPF 13:5
`define ODTC_F_IMMEDIATE_22 21:0
`define ODTC_F_LOW 10:0
`define ODTC_F_HIGH 31:11

// ****************************************
// Major classes, secondary and operation codes
// ****************************************
`define ODTC_OP_BR 2'h0
`define ODTC_OP_CALL 2'h1
`define ODTC_OP_ARITH 2'h2
`define ODTC_OP_LDST 2'h3
`define ODTC_OP2_EXPLICIT_ILLEGAL_TRAP 3'h0
`define ODTC_OP2_SET_HIGH_IMMEDIATE 3'h4
`define ODTC_OP2_EXTENDED_REGISTER_PREFIX 3'h7
`define ODTC_OP3_RDASR 6'h28
`define ODTC_OP3_WRASR 6'h30
`define ODTC_OP3_SLL 6'h25
`define ODTC_OP3_SRL 6'h26
`define ODTC_OP3_SRA 6'h27
`define ODTC_OP3_POPULATION_COUNT 6'h2E
`define ODTC_OP3_FP1 6'h34
`define ODTC_OP3_FP2 6'h35
`define ODTC_OP3_IMPL1 6'h36
`define ODTC_OP3_IMPL2 6'h37
`define ODTC_OP3_ALT_SPACE_DOUBLE_FLOAT_LOAD 6'h33
`define ODTC_OP3_QUAD_FLOAT_LOAD 6'h22
`define ODTC_OP3_STQFA 6'h36
`define ODTC_RES_ARITH 64'h8008_0200_2200_0000
`define ODTC_RES_LDST 64'h8F66_4F44_1000_1000

// ****************************************
// Ancillary state selection
// ****************************************
`define ODTC_WR_ASR_OK 32'hE3FF_004D
`define ODTC_RD_ASR_OK 32'hC3CF_007D
`define ODTC_ASR_PCR 5'h10
`define ODTC_ASR_BAR 5'h0F
`define ODTC_SIR_RS1 5'h01
`define ODTC_REG_ZERO 5'h00
`define ODTC_ASI_BLK_E0 8'hE0
`define ODTC_ASI_BLK_E1 8'hE1
`define ODTC_ASI_BLK_C 4'hC
`define ODTC_BLK_ALIGN 6'h3F
`define ODTC_ALIGN8 3'h7
`define ODTC_ALIGN4 2'h3
`define ODTC_FTT_OP_MISSING 3'h3
`define ODTC_PD_CALL_KIND 3'h7

// ****************************************
// Register map
// ****************************************
`define ODTC_ADDR_CONFIG 8'h00
`define ODTC_ADDR_STATUS 8'h04
`define ODTC_ADDR_TRAPCNT 8'h08
`define ODTC_ADDR_DECCNT 8'h0C
`define ODTC_CFG_CPRIV 0
`define ODTC_CFG_EXT 1
`define ODTC_CFG_RESET 2'h2
`define ODTC_RESP_OKAY 2'h0
`define ODTC_RESP_DECERR 2'h3

`endif

// file: odtc_pkg.sv
package odtc_pkg;
   typedef enum logic [4:0] {
      UNIT_NONE = 5'h00, UNIT_ALU = 5'h01, UNIT_BRANCH = 5'h02, UNIT_CALL = 5'h03,
      UNIT_SET_HIGH_IMMEDIATE = 5'h04, UNIT_NOP = 5'h05, UNIT_EXTENDED_REGISTER_PREFIX = 5'h06, UNIT_ASR_RD = 5'h07,
      UNIT_ASR_WR = 5'h08, UNIT_MEMORY_BARRIER = 5'h09, UNIT_STORE_BARRIER = 5'h0A, UNIT_SIR = 5'h0B,
      UNIT_SHIFT32 = 5'h0C, UNIT_SHIFT64 = 5'h0D, UNIT_POPULATION_COUNT = 5'h0E, UNIT_FP1 = 5'h0F,
      UNIT_FP2 = 5'h10, UNIT_IMPL1 = 5'h11, UNIT_IMPL2 = 5'h12, UNIT_LDST = 5'h13
   } odtc_unit_t;
   typedef enum logic [2:0] {
      TRAP_NONE = 3'h0, TRAP_ILLEGAL = 3'h1, TRAP_PRIV_ACTION = 3'h2,
      TRAP_FLOAT_MISC = 3'h3, TRAP_DATA_ACCESS = 3'h4, TRAP_DF_MISALIGN = 3'h5,
      TRAP_MEM_MISALIGN = 3'h6
   } odtc_trap_t;
endpackage : odtc_pkg

// file: odtc_fields_if.sv
`timescale 1ns/1ps
interface odtc_fields_if;
   logic [31:0] word;
   logic fp1_legal;
   logic fp2_legal;
   logic [31:0] fill_word;
   logic [31:0] pd_word;
   logic [2:0] pd_kind;
   modport core (output word, output fill_word, input fp1_legal, input fp2_legal,
                 input pd_word, input pd_kind);
   modport fpchk (input word, output fp1_legal, output fp2_legal);
   modport predec (input fill_word, output pd_word, output pd_kind);
endinterface : odtc_fields_if

// file: odtc_fpchk.sv
`timescale 1ns/1ps
`include "odtc_defs.svh"
module odtc_fpchk (
   odtc_fields_if.fpchk f
);
   // ****************************************
   // Implemented encodings of the two float groups
   // ****************************************
   function automatic logic odtc_fp1_ok(input logic [8:0] opf);
      case (opf)
         9'h001, 9'h002, 9'h003, 9'h005, 9'h006, 9'h007, 9'h009, 9'h00A, 9'h00B,
         9'h029, 9'h02A, 9'h02B, 9'h041, 9'h042, 9'h043, 9'h045, 9'h046, 9'h047,
         9'h049, 9'h04A, 9'h04B, 9'h04D, 9'h04E, 9'h04F, 9'h069, 9'h06E, 9'h081,
         9'h082, 9'h083, 9'h084, 9'h088, 9'h08C, 9'h0C4, 9'h0C6, 9'h0C7, 9'h0C8,
         9'h0C9, 9'h0CB, 9'h0CC, 9'h0CD, 9'h0CE, 9'h0D1, 9'h0D2, 9'h0D3: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : odtc_fp1_ok

   function automatic logic odtc_fp2_ok(input logic [8:0] opf);
      case (opf)
         9'h001, 9'h002, 9'h003, 9'h025, 9'h026, 9'h027, 9'h041, 9'h042, 9'h043,
         9'h045, 9'h046, 9'h047, 9'h051, 9'h052, 9'h053, 9'h055, 9'h056, 9'h057,
         9'h065, 9'h066, 9'h067, 9'h081, 9'h082, 9'h083, 9'h0A5, 9'h0A6, 9'h0A7,
         9'h0C1, 9'h0C2, 9'h0C3, 9'h0C5, 9'h0C6, 9'h0C7, 9'h0E5, 9'h0E6, 9'h0E7,
         9'h101, 9'h102, 9'h103, 9'h181, 9'h182, 9'h183: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : odtc_fp2_ok

   wire [8:0] opf = f.word[`ODTC_F_OPF];
   // Anything outside the lists is left unimplemented
   assign f.fp1_legal = odtc_fp1_ok(opf);
   assign f.fp2_legal = odtc_fp2_ok(opf);
endmodule : odtc_fpchk

// file: odtc_predecode.sv
`timescale 1ns/1ps
`include "odtc_defs.svh"
module odtc_predecode (
   odtc_fields_if.predec f
);
   wire [1:0] op = f.fill_word[`ODTC_F_OP];
   wire [2:0] op2 = f.fill_word[`ODTC_F_OP2];
   wire is_branch = (op == `ODTC_OP_BR) && (op2 != `ODTC_OP2_EXPLICIT_ILLEGAL_TRAP) &&
                    (op2 != `ODTC_OP2_SET_HIGH_IMMEDIATE) && (op2 != `ODTC_OP2_EXTENDED_REGISTER_PREFIX);

   // Kind travels beside the word, so the cached word never differs from memory
   assign f.pd_kind = (op == `ODTC_OP_CALL) ? `ODTC_PD_CALL_KIND :
                      (is_branch ? op2 : 3'h0);
   assign f.pd_word = {f.fill_word[`ODTC_F_HIGH], f.fill_word[`ODTC_F_LOW]};
endmodule : odtc_predecode

// file: odtc_decode.sv
// Overview of operation
// - Explicit illegal-trap encoding always raises an illegal-instruction trap.
// - Reserved opcodes trap unless they are an enabled implementation extension.
// - Reserved or unimplemented opcodes are never executed as valid operations.
// - Set-high with zero destination and zero immediate decodes as no-operation.
// - Write-ancillary destination picks target register; listed holes are reserved.
// - Read-ancillary first source picks source register; listed holes are reserved.
// - Read-ancillary source 15, dest 0: memory barrier if i set, else store barrier.
// - Write-ancillary dest 15, source 1, i set: software-initiated reset.
// - Shift opcodes: extended bit 0 gives 32-bit shift, 1 gives 64-bit.
// - Population count valid only with first source zero; else reserved.
// - Class 2 operations 34-37 go to float and implementation sub-decoders.
// - Unprivileged with counter-privilege set: perf control read or write traps.
// - Unprivileged, counter-privilege clear: reads pass, writes setting it trap.
// - Block double-float load misaligned: access, double-misalign or misalign trap.
// - Block double-float load never traps on a misaligned destination register.
// - Cached call/branch predecode keeps low 11 bits equal to the memory encoding.
// - Quad float loads/stores and reserved load/store opcodes trap as illegal.
// - Unimplemented float group encodings raise float trap, op-missing type.
`timescale 1ns/1ps
`include "odtc_defs.svh"
module odtc_decode import odtc_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic in_valid,
   input wire logic [31:0] in_word,
   input wire logic processor_privileged_flag,
   input wire logic in_pcr_wr_priv,
   input wire logic [5:0] in_addr_low,
   input wire logic [7:0] in_asi,
   input wire logic fill_valid,
   input wire logic [31:0] fill_word,
   output logic out_valid,
   output odtc_unit_t out_unit,
   output logic [4:0] out_asr_sel,
   output logic trap_valid,
   output odtc_trap_t trap_code,
   output logic [2:0] trap_ftt,
   output logic ic_wr_valid,
   output logic [31:0] ic_wr_word,
   output logic [2:0] ic_wr_kind
);
   function automatic logic odtc_bit(input logic [63:0] m, input logic [5:0] i);
      return m[i];
   endfunction : odtc_bit

   function automatic logic [2:0] odtc_addr_sel(input logic [7:0] a);
      case ({a[7:2], 2'b00})
         `ODTC_ADDR_CONFIG: return 3'h4;
         `ODTC_ADDR_STATUS: return 3'h5;
         `ODTC_ADDR_TRAPCNT: return 3'h6;
         `ODTC_ADDR_DECCNT: return 3'h7;
         default: return 3'h0;
      endcase
   endfunction : odtc_addr_sel

   odtc_fields_if fi ();
   assign fi.word = in_word;
   assign fi.fill_word = fill_word;
   odtc_fpchk u_fpchk (.f(fi));
   odtc_predecode u_predecode (.f(fi));

   logic [1:0] config_reg;
   // ****************************************
   // Field split and class decode
   // ****************************************
   wire [1:0] op = in_word[`ODTC_F_OP];
   wire [2:0] op2 = in_word[`ODTC_F_OP2];
   wire [5:0] op3 = in_word[`ODTC_F_OP3];
   wire [4:0] rd = in_word[`ODTC_F_RD];
   wire [4:0] rs1 = in_word[`ODTC_F_RS1];
   wire i_bit = in_word[`ODTC_F_I];
   wire x_bit = in_word[`ODTC_F_X];
   wire cpriv = config_reg[`ODTC_CFG_CPRIV];
   wire ext_en = config_reg[`ODTC_CFG_EXT];
   wire is_br = (op == `ODTC_OP_BR);
   wire is_call = (op == `ODTC_OP_CALL);
   wire is_arith = (op == `ODTC_OP_ARITH);
   wire is_ldst = (op == `ODTC_OP_LDST);
   wire br_explicit_illegal_trap = is_br && (op2 == `ODTC_OP2_EXPLICIT_ILLEGAL_TRAP);
   wire br_set_high_immediate = is_br && (op2 == `ODTC_OP2_SET_HIGH_IMMEDIATE);
   wire br_extended_register_prefix = is_br && (op2 == `ODTC_OP2_EXTENDED_REGISTER_PREFIX);
   wire br_nop = br_set_high_immediate && (rd == `ODTC_REG_ZERO) && (in_word[`ODTC_F_IMMEDIATE_22] == 22'h0);
   wire wrasr = is_arith && (op3 == `ODTC_OP3_WRASR);
   wire rdasr = is_arith && (op3 == `ODTC_OP3_RDASR);
   wire software_initiated_reset = wrasr && (rd == `ODTC_ASR_BAR) && (rs1 == `ODTC_SIR_RS1) && i_bit;
   wire wr_res = wrasr && !software_initiated_reset && !odtc_bit({32'h0, `ODTC_WR_ASR_OK}, {1'b0, rd});
   wire bar = rdasr && (rs1 == `ODTC_ASR_BAR) && (rd == `ODTC_REG_ZERO);
   wire rd_res = rdasr && !bar && !odtc_bit({32'h0, `ODTC_RD_ASR_OK}, {1'b0, rs1});
   wire shift = is_arith && ((op3 == `ODTC_OP3_SLL) || (op3 == `ODTC_OP3_SRL) ||
                             (op3 == `ODTC_OP3_SRA));
   wire population_count = is_arith && (op3 == `ODTC_OP3_POPULATION_COUNT);
   wire population_count_res = population_count && (rs1 != `ODTC_REG_ZERO);
   wire fp1 = is_arith && (op3 == `ODTC_OP3_FP1);
   wire fp2 = is_arith && (op3 == `ODTC_OP3_FP2);
   wire impl1 = is_arith && (op3 == `ODTC_OP3_IMPL1);
   wire impl2 = is_arith && (op3 == `ODTC_OP3_IMPL2);
   wire ar_res = is_arith && odtc_bit(`ODTC_RES_ARITH, op3);
   // Extension groups only escape the trap while software enables them
   wire impl_res = (impl1 || impl2) && !ext_en;
   wire ld_res = is_ldst && odtc_bit(`ODTC_RES_LDST, op3);

   // ****************************************
   // Block-transfer double float load alignment
   // ****************************************
   wire asi_blk = (in_asi == `ODTC_ASI_BLK_E0) || (in_asi == `ODTC_ASI_BLK_E1) ||
                  ((in_asi[7:4] == `ODTC_ASI_BLK_C) && (in_asi[2:1] != 2'b11));
   // Destination register number is deliberately not checked here
   wire alt_space_double_float_load_blk = is_ldst && (op3 == `ODTC_OP3_ALT_SPACE_DOUBLE_FLOAT_LOAD) && asi_blk;
   wire misal = alt_space_double_float_load_blk && ((in_addr_low & `ODTC_BLK_ALIGN) != 6'h0);
   wire al8 = ((in_addr_low[2:0] & `ODTC_ALIGN8) == 3'h0);
   wire al4 = ((in_addr_low[1:0] & `ODTC_ALIGN4) == 2'h0);
   wire [2:0] misal_code = al8 ? TRAP_DATA_ACCESS :
                           (al4 ? TRAP_DF_MISALIGN : TRAP_MEM_MISALIGN);

   // ****************************************
   // Privilege and trap selection
   // ****************************************
   wire pcr_rd = rdasr && (rs1 == `ODTC_ASR_PCR);
   wire pcr_wr = wrasr && (rd == `ODTC_ASR_PCR);
   wire priv_lock = cpriv && (pcr_rd || pcr_wr);
   wire priv_set = !cpriv && pcr_wr && in_pcr_wr_priv;
   wire priv_trap = !processor_privileged_flag && (priv_lock || priv_set);
   wire illegal = br_explicit_illegal_trap || wr_res || rd_res || population_count_res || ar_res || impl_res ||
                  ld_res;
   wire fp_trap = (fp1 && !fi.fp1_legal) || (fp2 && !fi.fp2_legal);
   wire [2:0] trap_next = !in_valid ? TRAP_NONE :
                          illegal ? TRAP_ILLEGAL :
                          priv_trap ? TRAP_PRIV_ACTION :
                          fp_trap ? TRAP_FLOAT_MISC :
                          misal ? misal_code : TRAP_NONE;
   wire any_trap = (trap_next != TRAP_NONE);

   // A trapping word never reaches an execution unit
   wire [4:0] unit_next = (!in_valid || any_trap) ? UNIT_NONE :
                          is_call ? UNIT_CALL :
                          br_nop ? UNIT_NOP :
                          br_set_high_immediate ? UNIT_SET_HIGH_IMMEDIATE :
                          br_extended_register_prefix ? UNIT_EXTENDED_REGISTER_PREFIX :
                          is_br ? UNIT_BRANCH :
                          software_initiated_reset ? UNIT_SIR :
                          wrasr ? UNIT_ASR_WR :
                          bar ? (i_bit ? UNIT_MEMORY_BARRIER : UNIT_STORE_BARRIER) :
                          rdasr ? UNIT_ASR_RD :
                          shift ? (x_bit ? UNIT_SHIFT64 : UNIT_SHIFT32) :
                          population_count ? UNIT_POPULATION_COUNT :
                          fp1 ? UNIT_FP1 :
                          fp2 ? UNIT_FP2 :
                          impl1 ? UNIT_IMPL1 :
                          impl2 ? UNIT_IMPL2 :
                          is_ldst ? UNIT_LDST : UNIT_ALU;
   wire [4:0] asr_next = wrasr ? rd : rs1;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_unit <= UNIT_NONE;
         out_asr_sel <= 5'h0;
         trap_valid <= 1'b0;
         trap_code <= TRAP_NONE;
         trap_ftt <= 3'h0;
      end else begin
         out_valid <= in_valid && !any_trap;
         out_unit <= odtc_unit_t'(unit_next);
         out_asr_sel <= asr_next;
         trap_valid <= any_trap;
         trap_code <= odtc_trap_t'(trap_next);
         trap_ftt <= (trap_next == TRAP_FLOAT_MISC) ? `ODTC_FTT_OP_MISSING : 3'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ic_wr_valid <= 1'b0;
         ic_wr_word <= 32'h0;
         ic_wr_kind <= 3'h0;
      end else begin
         ic_wr_valid <= fill_valid;
         ic_wr_word <= fi.pd_word;
         ic_wr_kind <= fi.pd_kind;
      end
   end

   // ****************************************
   // AXI4-Lite register slave
   // ****************************************
   logic aw_held_reg, w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [31:0] trap_cnt_reg, dec_cnt_reg;
   logic [2:0] last_trap_reg;
   logic [4:0] last_unit_reg;
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_held_reg && w_held_reg;
   wire [2:0] wsel = odtc_addr_sel(aw_addr_reg);
   wire [2:0] rsel = odtc_addr_sel(s_axi_araddr);
   wire wr_cfg = do_write && (wsel == 3'h4) && w_strb_reg[0];
   // Writing the trap counter clears it; a trap in that same cycle still counts
   wire clr_trap = do_write && (wsel == 3'h6);
   wire [31:0] status_word = {19'h0, last_unit_reg, 5'h0, last_trap_reg};
   wire [31:0] rd_mux = (rsel == 3'h4) ? {30'h0, config_reg} :
                        (rsel == 3'h5) ? status_word :
                        (rsel == 3'h6) ? trap_cnt_reg :
                        (rsel == 3'h7) ? dec_cnt_reg : 32'h0;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ODTC_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 3'h0) ? `ODTC_RESP_DECERR : `ODTC_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `ODTC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= (rsel == 3'h0) ? `ODTC_RESP_DECERR : `ODTC_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         config_reg <= `ODTC_CFG_RESET;
         trap_cnt_reg <= 32'h0;
         dec_cnt_reg <= 32'h0;
         last_trap_reg <= TRAP_NONE;
         last_unit_reg <= UNIT_NONE;
      end else begin
         if (wr_cfg) config_reg <= w_data_reg[1:0];
         trap_cnt_reg <= clr_trap ? {31'h0, any_trap} : trap_cnt_reg + {31'h0, any_trap};
         dec_cnt_reg <= dec_cnt_reg + {31'h0, in_valid && !any_trap};
         if (any_trap) last_trap_reg <= trap_next;
         if (in_valid && !any_trap) last_unit_reg <= unit_next;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   AST_EXPLICIT_ILLEGAL_TRAP: assert property (in_valid && br_explicit_illegal_trap |=> trap_code == TRAP_ILLEGAL)
      else $error("Illegal-trap encoding did not trap");
   AST_NOP: assert property (in_valid && br_nop |=> out_valid && out_unit == UNIT_NOP)
      else $error("Zero set-high not decoded as no-operation");
   AST_SIR: assert property (in_valid && software_initiated_reset |=> out_unit == UNIT_SIR && !trap_valid)
      else $error("Software reset encoding not issued");
   AST_BARRIER: assert property (in_valid && bar |=>
      out_unit == ($past(i_bit) ? UNIT_MEMORY_BARRIER : UNIT_STORE_BARRIER))
      else $error("Barrier variant wrong");
   AST_SHIFT: assert property (in_valid && shift |=>
      out_unit == ($past(x_bit) ? UNIT_SHIFT64 : UNIT_SHIFT32))
      else $error("Shift width wrong");
   AST_POPULATION_COUNT: assert property (in_valid && population_count && rs1 != 5'h0 |=> trap_code == TRAP_ILLEGAL)
      else $error("Reserved population count not trapped");
   AST_PCR_LOCK: assert property (in_valid && !processor_privileged_flag && cpriv &&
      (pcr_rd || pcr_wr) |=> trap_valid && trap_code == TRAP_PRIV_ACTION)
      else $error("Locked perf control access not trapped");
   AST_PCR_OPEN: assert property (in_valid && !cpriv && pcr_rd |=> !trap_valid)
      else $error("Open perf control read trapped");
   AST_ALT_SPACE_DOUBLE_FLOAT_LOAD: assert property (in_valid && misal && al8 |=> trap_code == TRAP_DATA_ACCESS)
      else $error("Block load 8-byte case wrong");
   AST_PD_LOW: assert property (fill_valid |=> ic_wr_word[10:0] == $past(fill_word[10:0]))
      else $error("Predecode altered low bits");
   AST_QUAD: assert property (in_valid && is_ldst && op3 == `ODTC_OP3_QUAD_FLOAT_LOAD |=>
      trap_valid && trap_code == TRAP_ILLEGAL)
      else $error("Quad load not trapped");
   AST_FP: assert property (in_valid && fp_trap && !illegal && !priv_trap |=>
      trap_code == TRAP_FLOAT_MISC && trap_ftt == `ODTC_FTT_OP_MISSING)
      else $error("Missing float op not trapped");
   AST_NO_EXEC: assert property (trap_valid |-> !out_valid && out_unit == UNIT_NONE)
      else $error("Trapped word dispatched");

   COV_FP1: cover property (in_valid && fp1 ##1 out_unit == UNIT_FP1);
   COV_PRIV: cover property (trap_code == TRAP_PRIV_ACTION);
   COV_MISAL: cover property (trap_code == TRAP_DF_MISALIGN);
   COV_AXI_WR: cover property (do_write ##1 s_axi_bvalid);
endmodule : odtc_decode

// file: odtc_fetch_model.sv
`timescale 1ns/1ps
module odtc_fetch_model (
   input wire logic clk_sys,
   output logic in_valid,
   output logic [31:0] in_word,
   output logic fill_valid,
   output logic [31:0] fill_word
);
   initial begin
      in_valid = 1'h0;
      fill_valid = 1'h0;
      in_word = 32'h0000_0000;
      fill_word = 32'h0000_0000;
   end
   // Idle words are inverted so a stale value never passes for a new one
   task issue(input logic [31:0] w, input logic f);
      @(posedge clk_sys);
      in_valid <= !f;
      fill_valid <= f;
      in_word <= w;
      fill_word <= w;
      @(posedge clk_sys);
      in_valid <= 1'h0;
      fill_valid <= 1'h0;
      in_word <= ~w;
      fill_word <= ~w;
   endtask : issue
endmodule : odtc_fetch_model

// file: odtc_decode_test.sv
`timescale 1ns/1ps
module odtc_decode_test;
   import odtc_pkg::*;
   logic clk_sys = 1'h0, reset_n = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, in_asi = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, in_word, fill_word, ic_wr_word;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic processor_privileged_flag = 1'h1, in_pcr_wr_priv = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic in_valid, fill_valid, out_valid, trap_valid, ic_wr_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [5:0] in_addr_low = 6'h00;
   logic [4:0] out_asr_sel;
   logic [2:0] trap_ftt, ic_wr_kind;
   logic [31:0] q;
   logic [1:0] r;
   odtc_unit_t out_unit;
   odtc_trap_t trap_code;
   int errors = 0, check_count = 0;
   odtc_decode u_odtc_decode (.*);
   odtc_fetch_model u_odtc_fetch_model (.*);
   always #2.5 clk_sys = ~clk_sys;
   // ****************************************
   // Shared tasks
   // ****************************************
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task final_report;
      $display("Checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   function automatic logic [31:0] enc(input logic [1:0] op, input logic [4:0] rd,
         input logic [5:0] o3, input logic [4:0] rs1, input logic [13:0] lo);
      return {op, rd, o3, rs1, lo};
   endfunction : enc
   task dec(input logic [31:0] w, input odtc_unit_t u, input odtc_trap_t t);
      u_odtc_fetch_model.issue(w, 1'h0);
      #1 cmp("unit", u, out_unit);
      cmp("trap", t, trap_code);
      cmp("out_valid", t == TRAP_NONE, out_valid);
   endtask : dec
   // Handshake flags are taken from settled values 1 ns after each edge
   task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb, har, hr;
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      for (int n = 0; n < 40; n++) begin
         #1 {ha, hw} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
         {hb, har} = {s_axi_bvalid && s_axi_bready, s_axi_arvalid && s_axi_arready};
         hr = s_axi_rvalid && s_axi_rready;
         {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 1'h0;
         if (hw) s_axi_wvalid <= 1'h0;
         if (har) s_axi_arvalid <= 1'h0;
         if (hb) s_axi_bready <= 1'h0;
         if (hr) s_axi_rready <= 1'h0;
         if (hb || hr) return;
      end
      errors++;
      final_report();
   endtask : axi
   // ****************************************
   // Scenarios
   // ****************************************
   task t_ops;
      dec(32'h0000_0000, UNIT_NONE, TRAP_ILLEGAL);
      dec(32'h0100_0000, UNIT_NOP, TRAP_NONE);
      dec(32'h0300_0001, UNIT_SET_HIGH_IMMEDIATE, TRAP_NONE);
      dec(32'h4000_0010, UNIT_CALL, TRAP_NONE);
      dec(enc(2, 0, 6'h28, 15, 14'h2000), UNIT_MEMORY_BARRIER, TRAP_NONE);
      dec(enc(2, 0, 6'h28, 15, 14'h0000), UNIT_STORE_BARRIER, TRAP_NONE);
      dec(enc(2, 15, 6'h30, 1, 14'h2000), UNIT_SIR, TRAP_NONE);
      cmp("asr_sel", 32'h0000_000F, {27'h0, out_asr_sel});
      dec(enc(2, 1, 6'h25, 1, 14'h0000), UNIT_SHIFT32, TRAP_NONE);
      dec(enc(2, 1, 6'h27, 1, 14'h1000), UNIT_SHIFT64, TRAP_NONE);
      dec(enc(2, 1, 6'h2E, 1, 14'h0000), UNIT_NONE, TRAP_ILLEGAL);
      dec(enc(2, 1, 6'h30, 0, 14'h0000), UNIT_NONE, TRAP_ILLEGAL);
      dec(enc(2, 1, 6'h28, 1, 14'h0000), UNIT_NONE, TRAP_ILLEGAL);
      dec(enc(2, 1, 6'h34, 0, 14'h0020), UNIT_FP1, TRAP_NONE);
      dec(enc(2, 1, 6'h34, 0, 14'h0000), UNIT_NONE, TRAP_FLOAT_MISC);
      cmp("ftt", 32'h0000_0003, {29'h0, trap_ftt});
      dec(enc(3, 0, 6'h22, 0, 14'h0000), UNIT_NONE, TRAP_ILLEGAL);
      $display("t_ops done");
   endtask : t_ops
   task t_pcr;
      axi(1'h1, 8'h00, 32'h0000_0003);
      axi(1'h0, 8'h00, 32'h0000_0000);
      cmp("config", 32'h0000_0003, q);
      processor_privileged_flag <= 1'h0;
      dec(enc(2, 1, 6'h28, 16, 14'h0000), UNIT_NONE, TRAP_PRIV_ACTION);
      axi(1'h1, 8'h00, 32'h0000_0002);
      dec(enc(2, 1, 6'h28, 16, 14'h0000), UNIT_ASR_RD, TRAP_NONE);
      in_pcr_wr_priv <= 1'h1;
      dec(enc(2, 16, 6'h30, 0, 14'h0000), UNIT_NONE, TRAP_PRIV_ACTION);
      axi(1'h0, 8'h40, 32'h0000_0000);
      cmp("unmapped_resp", 32'h0000_0003, {30'h0, r});
      cmp("unmapped_data", 32'h0000_0000, q);
      axi(1'h1, 8'h00, 32'h0000_0000);
      dec(enc(2, 1, 6'h36, 0, 14'h0000), UNIT_NONE, TRAP_ILLEGAL);
      axi(1'h0, 8'h04, 32'h0000_0000);
      cmp("status", 32'h0000_0701, q);
      axi(1'h1, 8'h00, 32'h0000_0002);
      dec(enc(2, 1, 6'h36, 0, 14'h0000), UNIT_IMPL1, TRAP_NONE);
      $display("t_pcr done");
   endtask : t_pcr
   task t_blk;
      in_asi <= 8'hE0;
      in_addr_low <= 6'h08;
      dec(enc(3, 0, 6'h33, 0, 14'h0000), UNIT_NONE, TRAP_DATA_ACCESS);
      in_addr_low <= 6'h04;
      dec(enc(3, 0, 6'h33, 0, 14'h0000), UNIT_NONE, TRAP_DF_MISALIGN);
      in_addr_low <= 6'h02;
      dec(enc(3, 0, 6'h33, 0, 14'h0000), UNIT_NONE, TRAP_MEM_MISALIGN);
      in_addr_low <= 6'h00;
      dec(enc(3, 3, 6'h33, 0, 14'h0000), UNIT_LDST, TRAP_NONE);
      u_odtc_fetch_model.issue(32'h4000_0555, 1'h1);
      #1 cmp("ic_low", 11'h555, ic_wr_word[10:0]);
      cmp("ic_kind", 3'h7, ic_wr_kind);
      cmp("ic_valid", 32'h0000_0001, {31'h0, ic_wr_valid});
      $display("t_blk done");
   endtask : t_blk
   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'h1;
      t_ops();
      t_pcr();
      t_blk();
      final_report();
   end
endmodule : odtc_decode_test
